// *** hdl/pert_core.v ***
// Event timestamp readout port and indirect trigger configuration,
// with eight time-based trigger units routed onto twelve output pins.
// Assumes time of day and event captures come from logic on clk_sys_in.
//
// Overview of operation
// - Multi-event status puts extended status word first, else timestamp.
// - Each timestamp is four 16-bit words through one data address.
// - Order: ns low, ns high, seconds low, seconds high.
// - Nanoseconds high word holds bits 29:16; top two bits read zero.
// - Data port holds a timestamp only while status says one is ready.
// - Status read advances data port, dropping unread words.
// - Extended status bit 2n+1 gives unit n edge direction, 1 rise.
// - Extended status bit 2n flags unit n detect; default zero.
// - Write with strobe set stores control bits for selected trigger.
// - Write with strobe clear selects trigger for next config read.
// - Bit 15 makes trigger emit a pulse rather than one edge.
// - Bit 14 makes trigger periodic; clear gives a single event.
// - Bit 13 fires a trigger at once when its time already passed.
// - Periodic trigger started late with bit 13 gives no notification.
// - Bit 12 reports completion or late error, interrupt if enabled.
// - Pin field routes trigger to pin 1 to 12; zero disconnects.
// - Bit 7 toggle mode inverts the output at trigger time.
// - Select field bits 3:1 choose the configuration target.
// - Write strobe self-clears and always reads as zero.
// - Bits 6:4 ignore writes, read zero; controls reset to zero.
// - Event status zero means no timestamp waits in the data port.
//
// Decided for this implementation: the Avalon-MM slave port.

`timescale 1ns/1ps
`include "pert_consts.vh"

module pert_core (
    input  wire        clk_sys_in,
    input  wire        rst_b_in,
    input  wire [4:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    input  wire [31:0] tod_sec_in,
    input  wire [29:0] tod_ns_in,
    input  wire        evt_push_in,
    input  wire [10:0] evt_status_in,
    input  wire [15:0] evt_ext_in,
    input  wire [29:0] evt_ns_in,
    input  wire [31:0] evt_sec_in,
    output wire        evt_full_out,
    input  wire        trig_int_en_in,
    output wire        trig_irq_out,
    output wire [11:0] gpio_out,
    output wire [11:0] gpio_oe_out
);

////////////////////////////////////////////////////////////////////////
// Helpers

function reached;
    input [31:0] now_s;
    input [29:0] now_n;
    input [31:0] at_s;
    input [29:0] at_n;
    begin
        reached = (now_s > at_s) || (now_s == at_s && now_n >= at_n);
    end
endfunction

// Entry: [88:78] status, [77:62] ext, [61:32] ns, [31:0] sec
function [15:0] edata_word;
    input [88:0] ent;
    input [2:0]  k;
    begin
        case (k)
            3'h0:    edata_word = ent[77:62];
            3'h1:    edata_word = ent[47:32];
            3'h2:    edata_word = {2'b00, ent[61:48]};
            3'h3:    edata_word = ent[15:0];
            3'h4:    edata_word = ent[31:16];
            default: edata_word = 16'h0000;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// Bus slave

reg         done_q;
reg  [15:0] rdata_q;
reg  [15:0] rd_val;
reg  [2:0]  page_q;
reg         ests_nz_q;

wire req      = avs_read_in | avs_write_in;
wire acc      = req & done_q;
wire be_ok    = &avs_byteenable_in[1:0];
wire wr       = acc & avs_write_in & be_ok;
wire rd       = acc & avs_read_in;
wire [15:0] wd = avs_writedata_in[15:0];
wire pg_evt   = (page_q == `PERT_PAGE_EVT);
wire pg_cfg   = (page_q == `PERT_PAGE_CFG);
wire a_page   = (avs_address_in == `PERT_IDX_PAGE);
wire a_trig   = pg_cfg & (avs_address_in == `PERT_IDX_TRIG);
wire a_tstat  = pg_cfg & (avs_address_in == `PERT_IDX_TSTAT);
wire a_tnsl   = pg_cfg & (avs_address_in == `PERT_IDX_TNSL);
wire a_tnsh   = pg_cfg & (avs_address_in == `PERT_IDX_TNSH);
wire a_tscl   = pg_cfg & (avs_address_in == `PERT_IDX_TSCL);
wire a_tsch   = pg_cfg & (avs_address_in == `PERT_IDX_TSCH);
wire a_twid   = pg_cfg & (avs_address_in == `PERT_IDX_TWID);
wire a_ests   = pg_evt & (avs_address_in == `PERT_IDX_ESTS);
wire a_edata  = pg_evt & (avs_address_in == `PERT_IDX_EDATA);

assign avs_waitrequest_out = req & ~done_q;
assign avs_readdata_out    = {16'h0000, rdata_q};

////////////////////////////////////////////////////////////////////////
// Event queue and current entry

reg  [88:0]        q_mem [0:`PERT_QDEPTH-1];
reg  [`PERT_QAW:0] q_wp_q;
reg  [`PERT_QAW:0] q_rp_q;
reg  [88:0]        cur_q;
reg                cur_ok_q;
reg  [2:0]         word_q;

wire q_empty = (q_wp_q == q_rp_q);
wire q_full  = (q_wp_q[`PERT_QAW] != q_rp_q[`PERT_QAW]) &&
               (q_wp_q[`PERT_QAW-1:0] == q_rp_q[`PERT_QAW-1:0]);
wire [88:0] q_head = q_mem[q_rp_q[`PERT_QAW-1:0]];
wire push = evt_push_in & ~q_full;
wire pop  = rd & a_ests & ests_nz_q & ~q_empty;
// Without multi-event the sequence starts one word later
wire [2:0] word_eff = word_q + {2'b00, ~cur_q[79]};

assign evt_full_out = q_full;

always @(posedge clk_sys_in) begin
    if (push) begin
        q_mem[q_wp_q[`PERT_QAW-1:0]] <= {evt_status_in, evt_ext_in,
                                         evt_ns_in, evt_sec_in};
    end
end

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        q_wp_q   <= {(`PERT_QAW+1){1'b0}};
        q_rp_q   <= {(`PERT_QAW+1){1'b0}};
        cur_q    <= 89'h0;
        cur_ok_q <= 1'b0;
        word_q   <= 3'h0;
    end else begin
        if (push) begin
            q_wp_q <= q_wp_q + {{`PERT_QAW{1'b0}}, 1'b1};
        end
        if (rd & a_ests) begin
            // Unread words of the old entry are dropped
            word_q <= 3'h0;
            if (pop) begin
                q_rp_q   <= q_rp_q + {{`PERT_QAW{1'b0}}, 1'b1};
                cur_q    <= q_head;
                cur_ok_q <= 1'b1;
            end else begin
                cur_ok_q <= 1'b0;
            end
        end else if (rd & a_edata & cur_ok_q & (word_eff < 3'h5)) begin
            word_q <= word_q + 3'h1;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Trigger configuration storage and units

reg  [15:0] cfg_q  [0:7];
reg  [31:0] tsec_q [0:7];
reg  [29:0] tns_q  [0:7];
reg  [15:0] wid_q  [0:7];
reg  [15:0] cnt_q  [0:7];
reg  [7:0]  armed_q;
reg  [7:0]  lvl_q;
reg  [7:0]  act_q;
reg  [7:0]  nolate_q;
reg  [2:0]  sel_q;
reg  [15:0] st_nsl_q;
reg  [15:0] st_nsh_q;
reg  [15:0] st_scl_q;
reg  [15:0] st_sch_q;
reg  [15:0] st_wid_q;
reg  [15:0] tstat_q;
reg  [11:0] gpio_q;
reg  [11:0] oe_q;
reg  [7:0]  fire;
reg  [7:0]  endp;
reg  [7:0]  arm;
reg  [7:0]  done_set;
reg  [7:0]  err_set;
reg  [11:0] gpio_d;
reg  [11:0] oe_d;
integer     i;
integer     j;
integer     k;
integer     p;

wire [31:0] st_sec = {st_sch_q, st_scl_q};
wire [29:0] st_ns  = {st_nsh_q[13:0], st_nsl_q};
wire late_now = reached(tod_sec_in, tod_ns_in, st_sec, st_ns);
wire cfg_wr   = wr & a_trig & wd[`PERT_B_WR];

always @* begin
    done_set = 8'h00;
    err_set  = 8'h00;
    fire     = 8'h00;
    endp     = 8'h00;
    arm      = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
        arm[j]  = cfg_wr & (wd[3:1] == j[2:0]);
        fire[j] = armed_q[j] &
                  reached(tod_sec_in, tod_ns_in,
                          tsec_q[j], tns_q[j]);
        endp[j] = act_q[j] & (cnt_q[j] == 16'h0001);
        // Late without fire-if-late: no firing; error only if notify set
        err_set[j] = arm[j] & late_now & ~wd[`PERT_B_LATE] &
                     wd[`PERT_B_NOTIFY];
        if (cfg_q[j][`PERT_B_NOTIFY]) begin
            if (cfg_q[j][`PERT_B_PER]) begin
                done_set[j] = fire[j] & ~nolate_q[j];
            end else if (cfg_q[j][`PERT_B_PULSE]) begin
                done_set[j] = endp[j];
            end else begin
                done_set[j] = fire[j];
            end
        end
    end
end

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        armed_q  <= 8'h00;
        lvl_q    <= 8'h00;
        act_q    <= 8'h00;
        nolate_q <= 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            cfg_q[i]  <= `PERT_CFG_RST;
            tsec_q[i] <= 32'h0;
            tns_q[i]  <= 30'h0;
            wid_q[i]  <= `PERT_WID_RST;
            cnt_q[i]  <= 16'h0;
        end
    end else begin
        for (i = 0; i < 8; i = i + 1) begin
            if (arm[i]) begin
                cfg_q[i]    <= wd & `PERT_CFG_MASK;
                tsec_q[i]   <= st_sec;
                tns_q[i]    <= st_ns;
                wid_q[i]    <= (st_wid_q == 16'h0) ? 16'h1 : st_wid_q;
                act_q[i]    <= 1'b0;
                nolate_q[i] <= late_now;
                armed_q[i]  <= ~late_now | wd[`PERT_B_LATE];
            end else if (fire[i]) begin
                armed_q[i] <= 1'b0;
                if (cfg_q[i][`PERT_B_TOGGLE]) begin
                    lvl_q[i] <= ~lvl_q[i];
                end else begin
                    lvl_q[i] <= 1'b1;
                end
                if (cfg_q[i][`PERT_B_PULSE] | cfg_q[i][`PERT_B_PER]) begin
                    act_q[i] <= 1'b1;
                    cnt_q[i] <= wid_q[i];
                end
            end else if (act_q[i]) begin
                if (endp[i]) begin
                    lvl_q[i] <= ~lvl_q[i];
                    if (cfg_q[i][`PERT_B_PER]) begin
                        cnt_q[i] <= wid_q[i];
                    end else begin
                        act_q[i] <= 1'b0;
                    end
                end else begin
                    cnt_q[i] <= cnt_q[i] - 16'h0001;
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Pin routing

always @* begin
    gpio_d = 12'h000;
    oe_d   = 12'h000;
    for (p = 0; p < 12; p = p + 1) begin
        for (k = 0; k < 8; k = k + 1) begin
            if (cfg_q[k][11:8] == p[3:0] + 4'h1) begin
                gpio_d[p] = gpio_d[p] | lvl_q[k];
                oe_d[p]   = 1'b1;
            end
        end
    end
end

assign gpio_out     = gpio_q;
assign gpio_oe_out  = oe_q;
assign trig_irq_out = trig_int_en_in & (|tstat_q);

////////////////////////////////////////////////////////////////////////
// Read mux

always @* begin
    rd_val = 16'h0000;
    if (a_page) begin
        rd_val = {13'h0, page_q};
    end else if (a_trig) begin
        // Strobe and reserved bits read zero
        rd_val = cfg_q[sel_q] | {12'h0, sel_q, 1'b0};
    end else if (a_tstat) begin
        rd_val = tstat_q;
    end else if (a_tnsl) begin
        rd_val = st_nsl_q;
    end else if (a_tnsh) begin
        rd_val = st_nsh_q;
    end else if (a_tscl) begin
        rd_val = st_scl_q;
    end else if (a_tsch) begin
        rd_val = st_sch_q;
    end else if (a_twid) begin
        rd_val = st_wid_q;
    end else if (a_ests) begin
        rd_val = q_empty ? 16'h0000 : {5'h00, q_head[88:78]};
    end else if (a_edata & cur_ok_q) begin
        rd_val = edata_word(cur_q, word_eff);
    end
end

////////////////////////////////////////////////////////////////////////
// Software registers

always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
        done_q    <= 1'b0;
        rdata_q   <= 16'h0000;
        ests_nz_q <= 1'b0;
        page_q    <= `PERT_PAGE_RST;
        sel_q     <= 3'h0;
        st_nsl_q  <= 16'h0;
        st_nsh_q  <= 16'h0;
        st_scl_q  <= 16'h0;
        st_sch_q  <= 16'h0;
        st_wid_q  <= `PERT_WID_RST;
        tstat_q   <= 16'h0;
        gpio_q    <= 12'h000;
        oe_q      <= 12'h000;
    end else begin
        gpio_q <= gpio_d;
        oe_q   <= oe_d;
        done_q <= req & ~done_q;
        if (req & ~done_q) begin
            rdata_q   <= rd_val;
            ests_nz_q <= ~q_empty;
        end
        if (wr & a_page) begin
            page_q <= wd[2:0];
        end
        if (wr & a_trig) begin
            sel_q <= wd[3:1];
        end
        if (wr & a_tnsl) begin
            st_nsl_q <= wd;
        end
        if (wr & a_tnsh) begin
            st_nsh_q <= {2'b00, wd[13:0]};
        end
        if (wr & a_tscl) begin
            st_scl_q <= wd;
        end
        if (wr & a_tsch) begin
            st_sch_q <= wd;
        end
        if (wr & a_twid) begin
            st_wid_q <= wd;
        end
        // Clear only what was reported; new events win
        if (rd & a_tstat) begin
            tstat_q <= (tstat_q & ~rdata_q) |
                       {err_set, done_set};
        end else begin
            tstat_q <= tstat_q | {err_set, done_set};
        end
    end
end

endmodule

// *** shared/pert_consts.vh ***
// Constants for the event readout and trigger configuration block.
// Assumes word-indexed register access; byte address is four times index.
`ifndef PERT_CONSTS_VH
`define PERT_CONSTS_VH

// Register indices
`define PERT_IDX_PAGE   5'h13
`define PERT_IDX_TRIG   5'h14
`define PERT_IDX_ESTS   5'h1e
`define PERT_IDX_EDATA  5'h1f
`define PERT_IDX_TSTAT  5'h0a
`define PERT_IDX_TNSL   5'h0c
`define PERT_IDX_TNSH   5'h0d
`define PERT_IDX_TSCL   5'h0e
`define PERT_IDX_TSCH   5'h0f
`define PERT_IDX_TWID   5'h10

// Pages
`define PERT_PAGE_EVT   3'h4
`define PERT_PAGE_CFG   3'h5

// Trigger register fields
`define PERT_B_PULSE    15
`define PERT_B_PER      14
`define PERT_B_LATE     13
`define PERT_B_NOTIFY   12
`define PERT_B_TOGGLE   7
`define PERT_B_WR       0
`define PERT_CFG_MASK   16'hff80

// Reset values
`define PERT_PAGE_RST   3'h0
`define PERT_CFG_RST    16'h0000
`define PERT_WID_RST    16'h0001

// Event queue depth as a power of two
`define PERT_QAW        2
`define PERT_QDEPTH     4

`endif

// *** tb/pert_core_checker.sv ***
// Bus and pin assertions for the event readout and trigger block.
// Assumes binding onto pert_core, one clock, reset active low.
`timescale 1ns/1ps
`include "pert_consts.vh"
module pert_core_checker (
    input wire        clk_sys_in,
    input wire        rst_b_in,
    input wire [4:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        trig_int_en_in,
    input wire        trig_irq_out,
    input wire [11:0] gpio_out,
    input wire [11:0] gpio_oe_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////
    sequence req_s;
        avs_read_in || avs_write_in;
    endsequence
    sequence trig_rd_s;
        avs_read_in && !avs_waitrequest_out
            && avs_address_in == `PERT_IDX_TRIG;
    endsequence
    ////////////////////////////////////////////////////////////////////
    wait_req_a: assert property (avs_waitrequest_out |-> req_s)
        else $error("wait without request");
    one_wait_a: assert property (req_s ##0 avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("more than one wait");
    first_wait_a: assert property ($rose(avs_read_in)
        |-> avs_waitrequest_out) else $error("read answered at once");
    trig_resv_a: assert property (trig_rd_s |->
        avs_readdata_out[6:4] == 3'h0 && !avs_readdata_out[0])
        else $error("trigger reserved or strobe bits set");
    hi_zero_a: assert property (
        avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read half not zero");
    irq_gate_a: assert property (
        !trig_int_en_in |-> !trig_irq_out)
        else $error("interrupt while disabled");
    pin_route_a: assert property (
        (gpio_out & ~gpio_oe_out) == 12'h000)
        else $error("pin driven high while not routed");
    rd_hold_a: assert property (!(avs_read_in || avs_write_in)
        |=> $stable(avs_readdata_out)) else $error("read data moved");
endmodule
bind pert_core pert_core_checker chk_u (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .trig_int_en_in(trig_int_en_in), .trig_irq_out(trig_irq_out),
    .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out));

// *** tb/tb_ptp_event_readout_trigger_config.sv ***
// Self-checking bench for the event readout and trigger block.
// Assumes pert_core with word-indexed Avalon registers.
`timescale 1ns/1ps
`include "pert_consts.vh"
module tb_ptp_event_readout_trigger_config;
    reg         clk_sys_in = 1'b0;
    reg         rst_b_in   = 1'b0;
    reg  [4:0]  addr       = 5'h00;
    reg         rd         = 1'b0;
    reg         wr         = 1'b0;
    reg  [31:0] wdata      = 32'h0;
    reg  [3:0]  be         = 4'hf;
    reg  [29:0] tod_ns     = 30'h0;
    reg  [31:0] tod_sec    = 32'h0;
    reg         push       = 1'b0;
    reg  [10:0] e_sts      = 11'h0;
    reg  [15:0] e_ext      = 16'h0;
    reg  [29:0] e_ns       = 30'h0;
    reg  [31:0] e_sec      = 32'h0;
    reg         int_en     = 1'b0;
    wire [31:0] rdata;
    wire        waitreq;
    wire        irq;
    wire [11:0] gpio;
    wire [11:0] gpio_oe;
    wire        full;
    integer     failures   = 0;
    integer     n_tests    = 0;
    integer     cyc        = 0;
    reg  [15:0] q;

    pert_core dut_u (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .tod_sec_in(tod_sec), .tod_ns_in(tod_ns), .evt_push_in(push),
        .evt_status_in(e_sts), .evt_ext_in(e_ext), .evt_ns_in(e_ns),
        .evt_sec_in(e_sec), .evt_full_out(full), .trig_int_en_in(int_en),
        .trig_irq_out(irq), .gpio_out(gpio), .gpio_oe_out(gpio_oe));

    always #2.5 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("checks %0d failures %0d", n_tests, failures);
            if (failures == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // One Avalon access, held until waitrequest is seen low
    task bus(input r, input [4:0] a, input [15:0] d);
        begin
            @(posedge clk_sys_in);
            addr <= a;
            rd <= r;
            wr <= !r;
            wdata <= {16'h0000, d};
            @(posedge clk_sys_in);
            while (waitreq !== 1'b0)
                @(posedge clk_sys_in);
            q = rdata[15:0];
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask
    task rchk(input [4:0] a, input [15:0] exp);
        begin
            bus(1'b1, a, 16'h0000);
            chk(q, exp);
        end
    endtask
    task push_evt(input [10:0] s, input [15:0] x, input [29:0] n,
                  input [31:0] sc);
        begin
            @(posedge clk_sys_in);
            push <= 1'b1;
            e_sts <= s;
            e_ext <= x;
            e_ns <= n;
            e_sec <= sc;
            @(posedge clk_sys_in);
            push <= 1'b0;
        end
    endtask
    function [15:0] cfgp(input [2:0] k);
        cfgp = {k[2], k[1], k[0], k[0], 4'h0, k[1], 7'h00};
    endfunction
    // Expected readback: stored controls plus select field
    function [15:0] cfgr(input [2:0] k);
        cfgr = cfgp(k) | {12'h0, k, 1'b0};
    endfunction
    ////////////////////////////////////////////////////////////////////
    task t_cfg;
        integer k;
        begin
            bus(1'b0, `PERT_IDX_PAGE, 16'h0005);
            rchk(`PERT_IDX_TRIG, 16'h0000);
            for (k = 0; k < 8; k = k + 1) begin
                bus(1'b0, `PERT_IDX_TRIG,
                    cfgp(k[2:0]) | {12'h007, k[2:0], 1'b1});
                rchk(`PERT_IDX_TRIG, cfgr(k[2:0]));
            end
            for (k = 0; k < 8; k = k + 1) begin
                bus(1'b0, `PERT_IDX_TRIG, {12'hff7, k[2:0], 1'b0});
                rchk(`PERT_IDX_TRIG, cfgr(k[2:0]));
            end
            be <= 4'h0;
            bus(1'b0, `PERT_IDX_TRIG, 16'h0003);
            be <= 4'hf;
            rchk(`PERT_IDX_TRIG, cfgr(3'h7));
            rchk(5'h02, 16'h0000);
        end
    endtask
    task t_fire;
        integer n;
        begin
            bus(1'b0, `PERT_IDX_TNSL, 16'h00c8);
            bus(1'b0, `PERT_IDX_TNSH, 16'h0000);
            bus(1'b0, `PERT_IDX_TSCL, 16'h0001);
            bus(1'b0, `PERT_IDX_TSCH, 16'h0000);
            bus(1'b0, `PERT_IDX_TWID, 16'h0004);
            tod_ns <= 30'd100;
            // Late edge unit 1 and pulse unit 5 notify; periodic ones not
            rchk(`PERT_IDX_TSTAT, 16'h0022);
            int_en <= 1'b1;
            bus(1'b0, `PERT_IDX_TRIG, 16'h9305);
            rchk(`PERT_IDX_TSTAT, 16'h0000);
            chk({4'h0, gpio_oe}, 16'h0004);
            chk({4'h0, gpio}, 16'h0000);
            // Nanoseconds past but seconds short: must not fire
            tod_ns <= 30'd300;
            repeat (3) @(posedge clk_sys_in);
            chk({4'h0, gpio}, 16'h0000);
            tod_sec <= 32'h1;
            tod_ns <= 30'd200;
            n = 0;
            while (gpio[2] !== 1'b1 && n < 10) begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            n = 0;
            while (gpio[2] === 1'b1 && n < 20) begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            chk(n[15:0], 16'h0004);
            n = 0;
            while (irq !== 1'b1 && n < 4) begin
                @(posedge clk_sys_in);
                n = n + 1;
            end
            chk({15'h0, irq}, 16'h0001);
            rchk(`PERT_IDX_TSTAT, 16'h0004);
            @(posedge clk_sys_in);
            chk({15'h0, irq}, 16'h0000);
        end
    endtask
    task t_evt;
        begin
            bus(1'b0, `PERT_IDX_PAGE, 16'h0004);
            rchk(`PERT_IDX_ESTS, 16'h0000);
            rchk(`PERT_IDX_EDATA, 16'h0000);
            push_evt(11'h0c1, 16'h0000, 30'h2abc_1234, 32'hdead_beef);
            push_evt(11'h003, 16'h8e0b, 30'h3fff_ffff, 32'h1234_5678);
            push_evt(11'h001, 16'h0000, 30'h0000_0005, 32'h0);
            push_evt(11'h001, 16'h0000, 30'h0000_0007, 32'h0);
            @(posedge clk_sys_in);
            chk({15'h0, full}, 16'h0001);
            rchk(`PERT_IDX_ESTS, 16'h00c1);
            rchk(`PERT_IDX_EDATA, 16'h1234);
            chk({15'h0, full}, 16'h0000);
            rchk(`PERT_IDX_EDATA, 16'h2abc);
            rchk(`PERT_IDX_EDATA, 16'hbeef);
            rchk(`PERT_IDX_EDATA, 16'hdead);
            rchk(`PERT_IDX_EDATA, 16'h0000);
            rchk(`PERT_IDX_ESTS, 16'h0003);
            rchk(`PERT_IDX_EDATA, 16'h8e0b);
            rchk(`PERT_IDX_EDATA, 16'hffff);
            rchk(`PERT_IDX_EDATA, 16'h3fff);
            rchk(`PERT_IDX_ESTS, 16'h0001);
            rchk(`PERT_IDX_EDATA, 16'h0005);
            rchk(`PERT_IDX_ESTS, 16'h0001);
            rchk(`PERT_IDX_EDATA, 16'h0007);
            rchk(`PERT_IDX_ESTS, 16'h0000);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        t_cfg;
        t_fire;
        t_evt;
        close_out;
    end
    always @(posedge clk_sys_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            close_out;
        end
    end
endmodule
